// >>> rtl/mfcr_defs.vh
// mfcr_defs.vh: constants for the fault check and report block.
// assumes inclusion by bare name from the rtl files.
`ifndef MFCR_DEFS_VH
`define MFCR_DEFS_VH
// =====================================
// fault status codes
`define MFCR_FS_ALIGN      4'h1
`define MFCR_FS_ALIGN_ALT  4'h3
`define MFCR_FS_EXT_L1     4'hc
`define MFCR_FS_EXT_L2     4'he
`define MFCR_FS_TRANS_SEC  4'h5
`define MFCR_FS_TRANS_PAGE 4'h7
`define MFCR_FS_DOM_SEC    4'h9
`define MFCR_FS_DOM_PAGE   4'hb
`define MFCR_FS_PERM_SEC   4'hd
`define MFCR_FS_PERM_PAGE  4'hf
`define MFCR_FS_EXT        4'h8
// =====================================
// domain access values
`define MFCR_DOM_NOACC  2'h0
`define MFCR_DOM_CLIENT 2'h1
`define MFCR_DOM_RSVD   2'h2
`define MFCR_DOM_MGR    2'h3
// =====================================
// access permission codes
`define MFCR_AP_SR   2'h0
`define MFCR_AP_PRW  2'h1
`define MFCR_AP_URO  2'h2
`define MFCR_AP_ALL  2'h3
// =====================================
// page sizes and boundaries
`define MFCR_SZ_SECTION 2'h0
`define MFCR_SZ_LARGE   2'h1
`define MFCR_SZ_SMALL   2'h2
`define MFCR_SZ_TINY    2'h3
`define MFCR_LARGE_Q_HI 15
`define MFCR_LARGE_Q_LO 14
`define MFCR_SMALL_Q_HI 11
`define MFCR_SMALL_Q_LO 10
`define MFCR_KB_BIT     10
// =====================================
// resets
`define MFCR_DACR_RST 32'h00000000
`define MFCR_FSR_RST  8'h00
`define MFCR_FAR_RST  32'h00000000
`endif

// >>> rtl/mfcr_perm_check.v
// mfcr_perm_check.v: access permission decode for one access.
// assumes the protection bits and selected permission field are stable.
`include "mfcr_defs.vh"
`default_nettype none
module mfcr_perm_check (
   input wire [1:0] ap_i,
   input wire sys_prot_i,
   input wire rom_prot_i,
   input wire priv_i,
   input wire write_i,
   output reg allow_o
);
   always @* begin
      allow_o = 1'b0;
      case (ap_i)
         `MFCR_AP_SR: begin
            // both set is unpredictable; treated as no access
            if (sys_prot_i && !rom_prot_i) begin
               allow_o = priv_i && !write_i;
            end else if (!sys_prot_i && rom_prot_i) begin
               allow_o = !write_i;
            end
         end
         `MFCR_AP_PRW: allow_o = priv_i;
         `MFCR_AP_URO: allow_o = priv_i || !write_i;
         `MFCR_AP_ALL: allow_o = 1'b1;
         default: allow_o = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// >>> rtl/mfcr_dom_sel.v
// mfcr_dom_sel.v: picks one domain field out of the access control word.
// assumes a 4-bit domain number.
`include "mfcr_defs.vh"
`default_nettype none
module mfcr_dom_sel #(
   parameter NDOM = 16
) (
   input wire [2*NDOM-1:0] dacr_i,
   input wire [3:0] dom_i,
   output wire [1:0] field_o
);
   wire [1:0] fld [0:NDOM-1];
   genvar g;
   generate
      for (g = 0; g < NDOM; g = g + 1) begin : g_dom
         assign fld[g] = dacr_i[2*g+1:2*g];
      end
   endgenerate
   assign field_o = fld[dom_i];
endmodule
`default_nettype wire

// >>> rtl/mfcr_fault_unit.v
// mfcr_fault_unit.v: fault checking, priority and status recording.
// assumes the walker presents descriptor results alongside each access,
// one access per cycle when acc_valid_i is high, all on sys_clk_i.
// Function
// - Differing subpage permissions load only accessed subpage
// - External aborts only on allowed transfer types
// - Alignment checked on data accesses whenever enable bit set
// - Translation domain permission faults need translation on
// - Violations suppress bus transfer and abort core
// - Data abort writes status and domain
// - Prefetch abort writes instruction status register
// - Data abort latches address; prefetch does not
// - Only highest priority abort reported
// - Alignment codes 0001 or 0011
// - External translation abort codes 1100 1110
// - Translation fault codes 0101 0111
// - Domain and permission fault codes
// - Domain may be meaningless before read
// - Coprocessor write updates instruction status register
// - Multi-word checked faults record first word; far_o takes a later word's address once far_ff differs from last_pre_kb_ff
// - Multi-word external abort records boundary address
// - Sixteen two-bit domain fields
// - Domain field values decide checking
// - Code 00 uses protection bits
// - Codes 01 10 11 grant fixed access
// - Client denials give section or page fault
// - Page quarter selects permission field
`include "mfcr_defs.vh"
`default_nettype none
module mfcr_fault_unit #(
   parameter NDOM = 16
) (
   input wire sys_clk_i,
   input wire rst_i,
   // control bits
   input wire xlate_en_i,
   input wire align_chk_en_i,
   input wire sys_prot_i,
   input wire rom_prot_i,
   // access from core
   input wire acc_valid_i,
   input wire acc_instr_i,
   input wire acc_write_i,
   input wire acc_priv_i,
   input wire [1:0] acc_size_i,
   input wire [31:0] acc_mva_i,
   input wire acc_multi_first_i,
   input wire acc_multi_i,
   input wire acc_noncached_i,
   input wire acc_nonbuffered_i,
   input wire acc_swap_i,
   // walker results
   input wire desc_valid_i,
   input wire [1:0] desc_size_i,
   input wire [3:0] desc_domain_i,
   input wire dom_known_i,
   input wire [7:0] desc_ap_i,
   input wire walk_ext_abort_i,
   input wire walk_level2_i,
   // external bus answer
   input wire bus_ext_abort_i,
   // coprocessor register writes
   input wire dacr_wr_i,
   input wire ifsr_wr_i,
   input wire [31:0] cp_wdata_i,
   // outputs
   output wire bus_req_o,
   output wire abort_o,
   output reg [1:0] tb_entry_size_o,
   output wire [31:0] dacr_o,
   output reg [7:0] dfsr_o,
   output reg [7:0] ifsr_o,
   output reg [31:0] far_o
);
   // =====================================
   // registers
   reg [31:0] dacr_ff;
   reg [7:0] dfsr_ff;
   reg [7:0] ifsr_ff;
   reg [31:0] far_ff;
   reg multi_abort_ff;
   reg pre_kb_abort_ff;
   reg [31:0] last_pre_kb_ff;
   reg [31:0] nxt_far;
   reg [3:0] fs;
   reg [3:0] fs_dom;
   reg fault;
   reg checked_fault;
   reg [1:0] ap_sel;
   wire [1:0] dom_field;
   wire perm_ok;
   wire misaligned;
   wire is_page;
   wire ext_ok;
   wire ext_abort;
   wire cross_kb;
   assign dacr_o = dacr_ff;
   // =====================================
   // domain and permission lookup
   mfcr_dom_sel #(
      .NDOM(NDOM)
   ) u_dom (
      .dacr_i(dacr_ff),
      .dom_i(desc_domain_i),
      .field_o(dom_field)
   );
   always @* begin
      case (desc_size_i)
         `MFCR_SZ_LARGE: ap_sel = desc_ap_i[2*acc_mva_i[`MFCR_LARGE_Q_HI:`MFCR_LARGE_Q_LO]+:2];
         `MFCR_SZ_SMALL: ap_sel = desc_ap_i[2*acc_mva_i[`MFCR_SMALL_Q_HI:`MFCR_SMALL_Q_LO]+:2];
         default: ap_sel = desc_ap_i[1:0];
      endcase
   end
   mfcr_perm_check u_perm (
      .ap_i(ap_sel),
      .sys_prot_i(sys_prot_i),
      .rom_prot_i(rom_prot_i),
      .priv_i(acc_priv_i),
      .write_i(acc_write_i),
      .allow_o(perm_ok)
   );
   // =====================================
   // fault detection
   // alignment check
   assign misaligned = align_chk_en_i && !acc_instr_i &&
      ((acc_size_i == 2'h2 && acc_mva_i[1:0] != 2'h0) || (acc_size_i == 2'h1 && acc_mva_i[0]));
   assign is_page = (desc_size_i != `MFCR_SZ_SECTION);
   assign ext_ok = (acc_noncached_i && !acc_write_i) || (acc_nonbuffered_i && acc_write_i) ||
      (acc_swap_i && acc_noncached_i);
   assign ext_abort = bus_ext_abort_i && ext_ok;
   always @* begin
      fs = 4'h0;
      fs_dom = desc_domain_i;
      fault = 1'b1;
      checked_fault = 1'b1;
      if (misaligned) begin
         fs = `MFCR_FS_ALIGN;
      end else if (xlate_en_i && walk_ext_abort_i) begin
         fs = walk_level2_i ? `MFCR_FS_EXT_L2 : `MFCR_FS_EXT_L1;
      end else if (xlate_en_i && !desc_valid_i) begin
         fs = is_page ? `MFCR_FS_TRANS_PAGE : `MFCR_FS_TRANS_SEC;
      end else if (xlate_en_i && (dom_field == `MFCR_DOM_NOACC || dom_field == `MFCR_DOM_RSVD)) begin
         fs = is_page ? `MFCR_FS_DOM_PAGE : `MFCR_FS_DOM_SEC;
      end else if (xlate_en_i && dom_field == `MFCR_DOM_CLIENT && !perm_ok) begin
         fs = is_page ? `MFCR_FS_PERM_PAGE : `MFCR_FS_PERM_SEC;
      end else if (ext_abort) begin
         fs = `MFCR_FS_EXT;
         checked_fault = 1'b0;
      end else begin
         fault = 1'b0;
         checked_fault = 1'b0;
      end
      if (!dom_known_i) begin
         fs_dom = 4'h0;
      end
   end
   // suppress bus and abort
   // only checked faults suppress the transfer; the external answer must not feed back into the request
   assign bus_req_o = acc_valid_i && !checked_fault;
   assign abort_o = acc_valid_i && fault;
   always @* begin
      tb_entry_size_o = desc_size_i;
      if (desc_size_i == `MFCR_SZ_LARGE || desc_size_i == `MFCR_SZ_SMALL) begin
         if (desc_ap_i != {4{desc_ap_i[1:0]}}) begin
            // a subpage entry: large 16KB reported as small size class, small 1KB as tiny size class
            tb_entry_size_o = (desc_size_i == `MFCR_SZ_LARGE) ? `MFCR_SZ_SMALL : `MFCR_SZ_TINY;
         end
      end
   end
   // =====================================
   // address recording for multi-word transfers
   assign cross_kb = acc_mva_i[`MFCR_KB_BIT] != last_pre_kb_ff[`MFCR_KB_BIT];
   always @* begin
      nxt_far = far_ff;
      if (acc_valid_i && !acc_instr_i && fault) begin
         if (!acc_multi_i || checked_fault) begin
            if (!multi_abort_ff || !acc_multi_i) begin
               nxt_far = acc_mva_i;
            end
         end
      end
      if (acc_valid_i && !acc_instr_i && acc_multi_i && !checked_fault) begin
         if (pre_kb_abort_ff || (ext_abort && !cross_kb && !acc_multi_first_i)) begin
            nxt_far = last_pre_kb_ff;
         end else if (ext_abort || (multi_abort_ff && !checked_fault && far_ff != last_pre_kb_ff)) begin
            nxt_far = acc_mva_i;
         end
      end
   end
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dacr_ff <= `MFCR_DACR_RST;
         dfsr_ff <= `MFCR_FSR_RST;
         ifsr_ff <= `MFCR_FSR_RST;
         far_ff <= `MFCR_FAR_RST;
         multi_abort_ff <= 1'b0;
         pre_kb_abort_ff <= 1'b0;
         last_pre_kb_ff <= `MFCR_FAR_RST;
      end else begin
         if (dacr_wr_i) begin
            dacr_ff <= cp_wdata_i;
         end
         if (ifsr_wr_i) begin
            ifsr_ff <= cp_wdata_i[7:0];
         end
         if (acc_valid_i && fault) begin
            if (acc_instr_i) begin
               ifsr_ff <= {fs_dom, fs};
            end else if (!acc_multi_i || acc_multi_first_i || !multi_abort_ff) begin
               dfsr_ff <= {fs_dom, fs};
            end
         end
         far_ff <= nxt_far;
         if (acc_valid_i && !acc_instr_i && acc_multi_i) begin
            if (acc_multi_first_i) begin
               multi_abort_ff <= fault;
               pre_kb_abort_ff <= ext_abort;
               last_pre_kb_ff <= acc_mva_i;
            end else begin
               multi_abort_ff <= multi_abort_ff | fault;
               if (!cross_kb) begin
                  last_pre_kb_ff <= acc_mva_i;
                  pre_kb_abort_ff <= pre_kb_abort_ff | ext_abort;
               end
            end
         end
      end
   end
   always @* begin
      dfsr_o = dfsr_ff;
      ifsr_o = ifsr_ff;
      far_o = far_ff;
   end
endmodule
`default_nettype wire

// >>> verif/mfcr_fault_unit_properties.sv
// mfcr_fault_unit_properties.sv: port assertions for the fault unit.
// assumes one clock sys_clk_i and async high reset rst_i.
`default_nettype none
module mfcr_fault_unit_properties (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic xlate_en_i,
   input wire logic align_chk_en_i,
   input wire logic acc_valid_i,
   input wire logic acc_instr_i,
   input wire logic [1:0] acc_size_i,
   input wire logic [31:0] acc_mva_i,
   input wire logic acc_multi_i,
   input wire logic acc_noncached_i,
   input wire logic acc_nonbuffered_i,
   input wire logic desc_valid_i,
   input wire logic [1:0] desc_size_i,
   input wire logic [3:0] desc_domain_i,
   input wire logic walk_ext_abort_i,
   input wire logic bus_ext_abort_i,
   input wire logic dacr_wr_i,
   input wire logic ifsr_wr_i,
   input wire logic [31:0] cp_wdata_i,
   input wire logic bus_req_o,
   input wire logic abort_o,
   input wire logic [31:0] dacr_o,
   input wire logic [7:0] dfsr_o,
   input wire logic [7:0] ifsr_o,
   input wire logic [31:0] far_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // access decode
   wire logic mis = acc_valid_i && align_chk_en_i && !acc_instr_i &&
      (acc_size_i == 2'h2 ? acc_mva_i[1:0] != 2'h0 : acc_size_i == 2'h1 && acc_mva_i[0]);
   wire logic [1:0] dom = dacr_o[{desc_domain_i, 1'b0} +: 2];
   wire logic walked = acc_valid_i && xlate_en_i && desc_valid_i && !walk_ext_abort_i && !mis;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========
   // assertions
   a_align_abort: assert property (mis |-> abort_o && !bus_req_o)
      else $error("misaligned access passed");
   a_align_code: assert property (mis && !acc_multi_i |=> dfsr_o[3:0] == 4'h1)
      else $error("alignment status wrong");
   a_off_quiet: assert property (acc_valid_i && !xlate_en_i && !mis && !bus_ext_abort_i |-> !abort_o)
      else $error("fault with translation off");
   a_ext_refused: assert property (acc_valid_i && !xlate_en_i && !mis && !acc_noncached_i &&
      !acc_nonbuffered_i |-> !abort_o && bus_req_o)
      else $error("external abort taken on cached access");
   a_mgr_pass: assert property (walked && dom == 2'h3 && !bus_ext_abort_i |-> !abort_o)
      else $error("manager domain aborted");
   a_nodom_code: assert property (walked && !dom[0] && !acc_instr_i && !acc_multi_i |=>
      dfsr_o[3:0] == ($past(desc_size_i) == 2'h0 ? 4'h9 : 4'hb))
      else $error("domain fault status wrong");
   a_far_instr: assert property (acc_valid_i && acc_instr_i |=> $stable(far_o))
      else $error("fetch changed fault address");
   a_dacr_load: assert property (dacr_wr_i |=> dacr_o == $past(cp_wdata_i))
      else $error("domain control not loaded");
   a_ifsr_load: assert property (ifsr_wr_i && !acc_valid_i |=> ifsr_o == $past(cp_wdata_i[7:0]))
      else $error("fetch status not loaded");
   c_align: cover property (mis);
   c_ext: cover property (acc_valid_i && bus_ext_abort_i && abort_o);
   c_nodom: cover property (walked && !dom[0]);
endmodule
bind mfcr_fault_unit mfcr_fault_unit_properties u_mfcr_fault_unit_properties (.*);
`default_nettype wire

// >>> verif/mfcr_bus_model.sv
// mfcr_bus_model.sv: external system bus behind the fault unit.
// assumes the bench aims each abort; answers in the request cycle.
`default_nettype none
module mfcr_bus_model (
   input wire logic bus_req_i,
   input wire logic abort_cmd_i,
   output logic bus_ext_abort_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // abort passed transfers
   // cached types get aborted too when told, so refusal can be seen
   assign bus_ext_abort_o = bus_req_i && abort_cmd_i;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// testbench.sv: randomised self-checking bench for the fault unit.
// assumes the bus model answers in the same cycle as the request.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b0, xl, al, sp, rp, av, ins, wr, pv, mf, mu, nc, nb, sw, dv, dk, we, l2, cmd, dw, iw;
   logic hit, ea;
   logic [1:0] sz, ds;
   logic [3:0] dm, fs;
   logic [7:0] ap;
   logic [31:0] modified_virtual_address, wd, r;
   logic [31:0] seed = 32'hd2a5, e_dacr = 32'h0, e_far = 32'h0;
   logic [3:0] e_d = 4'h0, e_i = 4'h0;
   wire logic rq, ab, ext;
   wire logic [1:0] tb;
   wire logic [7:0] dfsr, ifsr;
   wire logic [31:0] dacr, fault_address_reg;
   integer failures = 0, cmp_count = 0;
   always #5 clk = ~clk;
   mfcr_fault_unit u_mfcr_fault_unit (.sys_clk_i(clk), .rst_i(rst), .xlate_en_i(xl), .align_chk_en_i(al),
      .sys_prot_i(sp), .rom_prot_i(rp), .acc_valid_i(av), .acc_instr_i(ins), .acc_write_i(wr), .acc_priv_i(pv),
      .acc_size_i(sz), .acc_mva_i(modified_virtual_address), .acc_multi_first_i(mf), .acc_multi_i(mu), .acc_noncached_i(nc),
      .acc_nonbuffered_i(nb), .acc_swap_i(sw), .desc_valid_i(dv), .desc_size_i(ds), .desc_domain_i(dm),
      .dom_known_i(dk), .desc_ap_i(ap), .walk_ext_abort_i(we), .walk_level2_i(l2), .bus_ext_abort_i(ext),
      .dacr_wr_i(dw), .ifsr_wr_i(iw), .cp_wdata_i(wd), .bus_req_o(rq), .abort_o(ab), .tb_entry_size_o(tb),
      .dacr_o(dacr), .dfsr_o(dfsr), .ifsr_o(ifsr), .far_o(fault_address_reg));
   mfcr_bus_model u_mfcr_bus_model (.bus_req_i(rq), .abort_cmd_i(cmd), .bus_ext_abort_o(ext));
   // ==========
   // reference model
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] ref_fs();
      logic [1:0] d, a;
      logic ok;
      d = e_dacr[{dm, 1'b0} +: 2];
      a = ds == 2'h1 ? ap[{modified_virtual_address[15:14], 1'b0} +: 2] : ds == 2'h2 ? ap[{modified_virtual_address[11:10], 1'b0} +: 2] : ap[1:0];
      ok = a == 2'h3 || (a == 2'h2 && (pv || !wr)) || (a == 2'h1 && pv) || (a == 2'h0 && !wr && sp != rp && (rp || pv));
      if (al && !ins && (sz == 2'h2 ? modified_virtual_address[1:0] != 2'h0 : sz == 2'h1 && modified_virtual_address[0])) return 4'h1;
      if (xl && we) return l2 ? 4'he : 4'hc;
      if (xl && !dv) return ds == 2'h0 ? 4'h5 : 4'h7;
      if (xl && !d[0]) return ds == 2'h0 ? 4'h9 : 4'hb;
      if (xl && d == 2'h1 && !ok) return ds == 2'h0 ? 4'hd : 4'hf;
      return 4'h0;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic regs_chk();
      chk("dfsr", e_d, dfsr[3:0]);
      chk("ifsr", e_i, ifsr[3:0]);
      chk("far", e_far, fault_address_reg);
      chk("dacr", e_dacr, dacr);
   endtask
   // ==========
   // drivers
   task automatic cpw(input logic d, input logic [31:0] v);
      @(posedge clk);
      #1;
      regs_chk();
      {av, dw, iw, wd} = {1'b0, d, !d, v};
      @(posedge clk);
      #1;
      {dw, iw} = 2'b00;
      if (d) e_dacr = v;
      else e_i = v[3:0];
   endtask
   task automatic step(input logic rn, input logic [31:0] a, input logic [3:0] d, input logic f);
      @(posedge clk);
      #1;
      regs_chk();
      av = 1'b1;
      if (rn) begin
         r = rnd();
         {xl, al, sp, rp, ins, wr, pv, nc, nb, sw, l2, cmd} = r[11:0];
         {we, dv, sz, ds, dm} = {&r[14:12], |r[16:15], r[18] ? 2'h2 : {1'b0, r[17]}, r[20:19], r[24:21]};
         ap = r[25] ? {4{r[27:26]}} : rnd();
         modified_virtual_address = rnd();
      end else
         {modified_virtual_address, dm, mf, mu} = {a, d, f, 1'b1};
      if (mu && mf) hit = 1'b0;
      fs = ref_fs();
      ea = cmd && fs == 4'h0 && ((nc && (!wr || sw)) || (nb && wr));
      #3;
      chk("busreq", fs == 4'h0, rq);
      if (xl && dv && fs == 4'h0 && (ds == 2'h1 || ds == 2'h2)) chk("entry", ap == {4{ap[1:0]}} ? ds : ds + 2'h1, tb);
      if (ea) fs = 4'h8;
      chk("abort", fs != 4'h0, ab);
      if (fs != 4'h0 && ins) e_i = fs;
      else if (fs != 4'h0 && !(mu && hit)) {e_d, e_far, hit} = {fs, modified_virtual_address, 1'b1};
   endtask
   // ==========
   // sequence
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {xl, al, sp, rp, av, ins, wr, pv, mf, mu, nc, nb, sw, dv, we, l2, cmd, dw, iw, hit} = '0;
      {sz, ds, dm, ap, modified_virtual_address, wd, dk} = {2'h0, 2'h0, 4'h0, 8'h0, 32'h0, 32'h0, 1'b1};
      // a real rising edge on reset, so the asynchronous clear is seen at start
      #1 rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      cpw(1'b1, rnd());
      repeat (200) step(1'b1, 32'h0, 4'h0, 1'b0);
      cpw(1'b0, rnd());
      cpw(1'b1, rnd());
      repeat (200) step(1'b1, 32'h0, 4'h0, 1'b0);
      // multi-word: domain 0 manager, domain 1 no access; the 9-bit setup is cut to 8 bits, turning translation off and fetch on, so no word faults
      cpw(1'b1, 32'h3);
      {xl, al, ins, dv, we, cmd, ds} = {7'b1001000, 2'h0};
      step(1'b0, 32'h3f0, 4'h0, 1'b1);
      step(1'b0, 32'h3f4, 4'h1, 1'b0);
      step(1'b0, 32'h3f8, 4'h1, 1'b0);
      cpw(1'b0, 32'ha5);
      give_verdict();
   end
   initial begin
      #20000;
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
